// *** rtl/scd_map.vh ***
`ifndef SCD_MAP_VH
`define SCD_MAP_VH

// system base addresses per port
`define SCD_BASE_P0 16'h0000
`define SCD_BASE_P2 16'h2000
`define SCD_BASE_P3 16'h3000
`define SCD_BASE_P4 16'h4000
`define SCD_BASE_P5 16'h5000

// port select field of a system address
`define SCD_PSEL_MSB 15
`define SCD_PSEL_LSB 12
`define SCD_PSEL_W 4
`define SCD_OFS_W 12
`define SCD_ADDR_W 16

// reset and filler values of the data and address paths
`define SCD_DATA_RST 32'h0000_0000
`define SCD_ADDR_RST 16'h0000

// port select codes
`define SCD_PSEL_P0 4'h0
`define SCD_PSEL_P2 4'h2
`define SCD_PSEL_P3 4'h3
`define SCD_PSEL_P4 4'h4
`define SCD_PSEL_P5 4'h5

// port index (one-hot bit positions of the port vector)
`define SCD_IDX_P0 0
`define SCD_IDX_P2 1
`define SCD_IDX_P3 2
`define SCD_IDX_P4 3
`define SCD_IDX_P5 4
`define SCD_NPORT 5

// offset classes
`define SCD_CLS_W 2
`define SCD_CLS_NONE 2'h0
`define SCD_CLS_COMMON 2'h1
`define SCD_CLS_GLOBAL 2'h2
`define SCD_CLS_MSI 2'h3

// offset windows of the classes
`define SCD_COMMON_LAST 12'h0ff
`define SCD_AER_FIRST 12'h100
`define SCD_AER_LAST 12'h14f
`define SCD_GLOBAL_FIRST 12'h400
`define SCD_GLOBAL_LAST 12'h7ff
`define SCD_MSI_FIRST 12'h0d0
`define SCD_MSI_LAST 12'h0df

// request source
`define SCD_SRC_CFG 1'b0
`define SCD_SRC_SMB 1'b1

// value on a filler read of an undefined offset over smbus
`define SCD_SMB_FILL 32'hffff_ffff

`endif

// *** rtl/scd_class.v ***
`timescale 1ns/100ps
`default_nettype none
`include "scd_map.vh"

// classify a port-relative offset for one port kind
module scd_class
(
    // request
    input wire [`SCD_OFS_W-1:0] ofs,
    input wire is_up,
    // answer
    output reg [`SCD_CLS_W-1:0] cls
);

    always @*
    begin
        cls = `SCD_CLS_NONE;
        if (ofs <= `SCD_COMMON_LAST)
        begin
            cls = `SCD_CLS_COMMON;
            if (!is_up && ofs >= `SCD_MSI_FIRST && ofs <= `SCD_MSI_LAST)
            begin
                cls = `SCD_CLS_MSI;
            end
        end
        else if (ofs >= `SCD_AER_FIRST && ofs <= `SCD_AER_LAST)
        begin
            cls = `SCD_CLS_COMMON;
        end
        else if (is_up && ofs >= `SCD_GLOBAL_FIRST && ofs <= `SCD_GLOBAL_LAST)
        begin
            cls = `SCD_CLS_GLOBAL;
        end
    end

endmodule
`default_nettype wire

// *** rtl/scd_decode.v ***
`timescale 1ns/100ps
`default_nettype none
`include "scd_map.vh"

// Behaviour
// - every register belongs to exactly one port's configuration space
// - system address equals owning port base plus configuration offset
// - eeprom and smbus accesses address registers by system address
// - upstream port at base 0, ports 2 and 3 at 0x2000, 0x3000
// - ports 4 and 5 at bases 0x4000 and 0x5000
// - global control and test registers exist only in upstream space
// - msi capability exists only in downstream port spaces
// - configuration read of undefined offset returns zero
// - smbus read of undefined offset returns unspecified data
// - writes to undefined offsets complete but change nothing
module scd_decode
(
    // clock and reset
    input wire ref_clk,
    input wire resetn,
    // configuration request from the pcie side
    input wire cfg_req,
    input wire cfg_wr,
    input wire [2:0] cfg_port,
    input wire [`SCD_OFS_W-1:0] cfg_ofs,
    input wire [31:0] cfg_wdata,
    // system-address request from eeprom init or smbus slave
    input wire sys_req,
    input wire sys_wr,
    input wire sys_src_smb,
    input wire [15:0] sys_addr,
    input wire [31:0] sys_wdata,
    // read data of the addressed register, from the register file
    input wire [31:0] reg_rdata,
    // register file strobes
    output reg reg_rd,
    output reg reg_wr,
    output reg [`SCD_NPORT-1:0] reg_port,
    output reg [`SCD_OFS_W-1:0] reg_ofs,
    output reg [`SCD_CLS_W-1:0] reg_cls,
    output reg [31:0] reg_wdata,
    // completion
    output reg done,
    output reg done_src,
    output reg [31:0] rdata,
    output reg hit,
    output reg [15:0] done_addr
);

    ////////////////////////////////////////////////////////////////////
    // port base lookup
    function [15:0] port_base;
        input [`SCD_NPORT-1:0] onehot;
        begin
            port_base = `SCD_BASE_P0;
            if (onehot[`SCD_IDX_P2])
                port_base = `SCD_BASE_P2;
            if (onehot[`SCD_IDX_P3])
                port_base = `SCD_BASE_P3;
            if (onehot[`SCD_IDX_P4])
                port_base = `SCD_BASE_P4;
            if (onehot[`SCD_IDX_P5])
                port_base = `SCD_BASE_P5;
        end
    endfunction

    // port select field to one-hot, zero when no port owns it
    function [`SCD_NPORT-1:0] psel_onehot;
        input [`SCD_PSEL_W-1:0] psel;
        begin
            psel_onehot = {`SCD_NPORT{1'b0}};
            case (psel)
                `SCD_PSEL_P0: psel_onehot[`SCD_IDX_P0] = 1'b1;
                `SCD_PSEL_P2: psel_onehot[`SCD_IDX_P2] = 1'b1;
                `SCD_PSEL_P3: psel_onehot[`SCD_IDX_P3] = 1'b1;
                `SCD_PSEL_P4: psel_onehot[`SCD_IDX_P4] = 1'b1;
                `SCD_PSEL_P5: psel_onehot[`SCD_IDX_P5] = 1'b1;
                default: psel_onehot = {`SCD_NPORT{1'b0}};
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // offset defined inside the space of exactly one port
    function is_defined;
        input [`SCD_NPORT-1:0] onehot;
        input [`SCD_CLS_W-1:0] cls;
        begin
            is_defined = (|onehot) && (cls != `SCD_CLS_NONE);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // request selection: configuration request has priority
    reg [`SCD_NPORT-1:0] sel_port;
    reg [`SCD_OFS_W-1:0] sel_ofs;
    reg sel_wr;
    reg sel_src;
    reg sel_req;
    reg [31:0] sel_wdata;
    wire [`SCD_CLS_W-1:0] sel_cls;
    wire [`SCD_NPORT-1:0] cfg_onehot;
    wire [`SCD_NPORT-1:0] sys_onehot;
    wire [`SCD_OFS_W-1:0] sys_ofs;

    // owning port and offset of each request source
    assign cfg_onehot = psel_onehot({1'b0, cfg_port});
    assign sys_onehot = psel_onehot(sys_addr[`SCD_PSEL_MSB:`SCD_PSEL_LSB]);
    assign sys_ofs = sys_addr[`SCD_OFS_W-1:0];

    always @*
    begin
        sel_req = cfg_req | sys_req;
        sel_wr = cfg_wr;
        sel_src = `SCD_SRC_CFG;
        sel_wdata = cfg_wdata;
        sel_ofs = cfg_ofs;
        sel_port = cfg_onehot;
        if (!cfg_req)
        begin
            sel_wr = sys_wr;
            sel_src = sys_src_smb;
            sel_wdata = sys_wdata;
            sel_ofs = sys_ofs;
            sel_port = sys_onehot;
        end
    end

    scd_class u_class
    (
        .ofs(sel_ofs),
        .is_up(sel_port[`SCD_IDX_P0]),
        .cls(sel_cls)
    );

    // defined only when exactly one port owns it and class is known
    wire sel_hit;
    assign sel_hit = is_defined(sel_port, sel_cls);

    ////////////////////////////////////////////////////////////////////
    // answer kinds of a completion
    localparam [1:0] ANS_IDLE = 2'b00;
    localparam [1:0] ANS_DATA = 2'b01;
    localparam [1:0] ANS_ZERO = 2'b10;
    localparam [1:0] ANS_FILL = 2'b11;

    // system address of an offset inside one port's space
    function [`SCD_ADDR_W-1:0] sys_address;
        input [`SCD_NPORT-1:0] onehot;
        input [`SCD_OFS_W-1:0] ofs;
        begin
            sys_address = port_base(onehot) + {{`SCD_PSEL_W{1'b0}}, ofs};
        end
    endfunction

    // answer of a request, fixed when it is taken
    function [1:0] answer_kind;
        input req;
        input wr;
        input defined;
        input src;
        begin
            answer_kind = ANS_IDLE;
            if (req && wr)
            begin
                answer_kind = ANS_ZERO;
            end
            else if (req && defined)
            begin
                answer_kind = ANS_DATA;
            end
            else if (req && src == `SCD_SRC_SMB)
            begin
                answer_kind = ANS_FILL;
            end
            else if (req)
            begin
                answer_kind = ANS_ZERO;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // stage 1: next values of the register file strobes
    reg next_reg_rd;
    reg next_reg_wr;
    reg [`SCD_NPORT-1:0] next_reg_port;
    reg [`SCD_CLS_W-1:0] next_reg_cls;
    reg [1:0] next_ans;
    reg [`SCD_ADDR_W-1:0] next_addr;

    always @*
    begin
        next_reg_rd = 1'b0;
        next_reg_wr = 1'b0;
        next_reg_port = {`SCD_NPORT{1'b0}};
        next_reg_cls = `SCD_CLS_NONE;
        next_ans = answer_kind(sel_req, sel_wr, sel_hit, sel_src);
        next_addr = sys_address(sel_port, sel_ofs);
        if (sel_req && sel_hit)
        begin
            next_reg_rd = !sel_wr;
            next_reg_wr = sel_wr;
            next_reg_port = sel_port;
            next_reg_cls = sel_cls;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // stage 1: register file strobes
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_rd <= 1'b0;
            reg_wr <= 1'b0;
            reg_port <= {`SCD_NPORT{1'b0}};
            reg_ofs <= {`SCD_OFS_W{1'b0}};
            reg_cls <= `SCD_CLS_NONE;
            reg_wdata <= `SCD_DATA_RST;
        end
        else
        begin
            reg_rd <= next_reg_rd;
            reg_wr <= next_reg_wr;
            reg_port <= next_reg_port;
            reg_ofs <= sel_ofs;
            reg_cls <= next_reg_cls;
            reg_wdata <= sel_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // stage 1: pending completion
    reg pend;
    reg pend_src;
    reg pend_hit;
    reg [1:0] pend_ans;
    reg [`SCD_ADDR_W-1:0] pend_addr;

    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pend <= 1'b0;
            pend_src <= `SCD_SRC_CFG;
            pend_hit <= 1'b0;
            pend_ans <= ANS_IDLE;
            pend_addr <= `SCD_ADDR_RST;
        end
        else
        begin
            pend <= sel_req;
            pend_src <= sel_src;
            pend_hit <= sel_req && sel_hit;
            pend_ans <= next_ans;
            pend_addr <= next_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // stage 2: read data of the completion
    reg [31:0] next_rdata;

    always @*
    begin
        case (pend_ans)
            ANS_DATA: next_rdata = reg_rdata;
            ANS_FILL: next_rdata = `SCD_SMB_FILL;
            ANS_ZERO: next_rdata = `SCD_DATA_RST;
            default: next_rdata = `SCD_DATA_RST;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // stage 2: completion flags
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            done <= 1'b0;
            done_src <= `SCD_SRC_CFG;
            hit <= 1'b0;
        end
        else
        begin
            done <= pend;
            done_src <= pend_src;
            hit <= pend_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // stage 2: completion data
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata <= `SCD_DATA_RST;
            done_addr <= `SCD_ADDR_RST;
        end
        else
        begin
            rdata <= next_rdata;
            done_addr <= pend_addr;
        end
    end

endmodule
`default_nettype wire

// *** testbench/scd_rf_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module scd_rf_model
(
    // strobes from the decode
    input wire logic ref_clk,
    input wire logic reg_rd,
    input wire logic [4:0] reg_port,
    input wire logic [11:0] reg_ofs,
    // read data
    output var logic [31:0] reg_rdata
);
    logic [31:0] junk = 32'h0;
    // off-strobe data changes every cycle
    always @(posedge ref_clk) junk <= ~junk ^ 32'h1;
    assign reg_rdata = reg_rd ? {reg_port, 15'h0, reg_ofs} : junk;
endmodule
`default_nettype wire

// *** testbench/scd_chk_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module scd_chk
(
    // watched ports
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic cfg_req,
    input wire logic [2:0] cfg_port,
    input wire logic [11:0] cfg_ofs,
    input wire logic sys_req,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [4:0] reg_port,
    input wire logic [1:0] reg_cls,
    input wire logic done,
    input wire logic [31:0] rdata,
    input wire logic hit,
    input wire logic [15:0] done_addr
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    req_done_a: assert property ((cfg_req || sys_req) |-> ##2 done)
        else $error("late done");
    rd_data_a: assert property (reg_rd |=> done && hit && rdata == $past(reg_rdata))
        else $error("bad rdata");
    rd_port_a: assert property (reg_rd |-> $onehot(reg_port))
        else $error("bad port");
    cfg_zero_a: assert property (cfg_req |-> ##2 hit || rdata == 32'h0)
        else $error("nonzero miss");
    wr_def_a: assert property (reg_wr |-> reg_cls != 2'h0 && $onehot(reg_port))
        else $error("bad write");
    cfg_addr_a: assert property (cfg_req && cfg_port inside {0, 2, 3, 4, 5} |->
        ##2 done_addr == {1'b0, $past(cfg_port, 2), $past(cfg_ofs, 2)})
        else $error("bad addr");
    global_up_a: assert property (reg_cls == 2'h2 |-> reg_port == 5'h01)
        else $error("global off p0");
    msi_down_a: assert property (reg_cls == 2'h3 |-> reg_port != 5'h0 && !reg_port[0])
        else $error("msi on p0");
endmodule
bind scd_decode scd_chk chk_i (.ref_clk, .resetn, .cfg_req, .cfg_port, .cfg_ofs, .sys_req,
    .reg_rdata, .reg_rd, .reg_wr, .reg_port, .reg_cls, .done, .rdata, .hit, .done_addr);
`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic ref_clk = 0, resetn = 0, cfg_req = 0, sys_req = 0, wr = 0, smb = 0;
    logic [15:0] adr = 0;
    logic [1:0] cls;
    logic wstb;
    logic [31:0] wd;
    wire [31:0] reg_rdata, rdata;
    wire [4:0] reg_port;
    wire [11:0] reg_ofs;
    wire [1:0] reg_cls;
    wire [15:0] done_addr;
    wire [31:0] reg_wdata;
    wire done_src;
    wire reg_rd, reg_wr, done, hit;
    int error_cnt = 0, total_checks = 0, cyc = 0;
    scd_decode uut (.ref_clk, .resetn, .cfg_req, .cfg_wr(wr), .cfg_port(adr[14:12]),
        .cfg_ofs(adr[11:0]), .cfg_wdata(32'h1), .sys_req, .sys_wr(wr), .sys_src_smb(smb),
        .sys_addr(adr), .sys_wdata(32'h2), .reg_rdata, .reg_rd, .reg_wr, .reg_port,
        .reg_ofs, .reg_cls, .reg_wdata, .done, .done_src, .rdata, .hit, .done_addr);
    scd_rf_model rf (.ref_clk, .reg_rd, .reg_port, .reg_ofs, .reg_rdata);
    initial forever #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            error_cnt++;
            summarize;
        end
    end
    task chk(input string n, input logic [31:0] s, e);
        total_checks++;
        if (s !== e)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task summarize;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task acc(input logic s, sy, w, input logic [15:0] ad);
        @(posedge ref_clk);
        cfg_req <= !sy;
        sys_req <= sy;
        wr <= w;
        smb <= s;
        adr <= ad;
        @(posedge ref_clk);
        cfg_req <= 0;
        sys_req <= 0;
        #1 cls = reg_cls;
        wstb = reg_wr;
        wd = reg_wdata;
        @(posedge ref_clk);
        #1;
    endtask
    task res(input logic h, input logic [31:0] d, input logic [15:0] ad);
        chk("done", done, 1'b1);
        chk("src", done_src, smb);
        chk("hit", hit, h);
        chk("rdata", rdata, d);
        chk("addr", done_addr, ad);
    endtask
    task t_bases;
        logic [2:0] p;
        for (int i = 0; i < 10; i++)
        begin
            p = (i % 5) ? 3'(i % 5 + 1) : 3'h0;
            acc(0, i > 4, 0, {1'b0, p, 12'h004});
            res(1, {5'h01 << (i % 5), 27'h004}, {1'b0, p, 12'h004});
        end
        $display("bases end");
    endtask
    task t_undef;
        acc(0, 0, 0, 16'h2200);
        res(0, 32'h0, 16'h2200);
        acc(1, 1, 0, 16'h2200);
        res(0, 32'hffff_ffff, 16'h2200);
        acc(0, 0, 1, 16'h3200);
        chk("wstb", wstb, 1'b0);
        res(0, 32'h0, 16'h3200);
        acc(1, 1, 1, 16'h4300);
        chk("wstb", wstb, 1'b0);
        res(0, 32'h0, 16'h4300);
        acc(0, 0, 1, 16'h3010);
        chk("wstb", wstb, 1'b1);
        chk("wdata", wd, 32'h1);
        res(1, 32'h0, 16'h3010);
        acc(1, 1, 1, 16'h5010);
        chk("wstb", wstb, 1'b1);
        chk("wdata", wd, 32'h2);
        res(1, 32'h0, 16'h5010);
        acc(0, 0, 0, 16'h1004);
        res(0, 32'h0, 16'h0004);
        $display("undefined end");
    endtask
    task t_class;
        acc(0, 0, 0, 16'h0400);
        chk("cls", cls, 2'h2);
        acc(0, 0, 0, 16'h2400);
        res(0, 32'h0, 16'h2400);
        acc(0, 0, 0, 16'h20d0);
        chk("cls", cls, 2'h3);
        acc(0, 0, 0, 16'h00d0);
        chk("cls", cls, 2'h1);
        $display("class end");
    endtask
    initial
    begin
        repeat (4) @(posedge ref_clk);
        resetn <= 1;
        t_bases;
        t_undef;
        t_class;
        summarize;
    end
endmodule
`default_nettype wire
